// ===== core/frfs_regs.svh
`ifndef FRFS_REGS_SVH
`define FRFS_REGS_SVH
`define FRFS_OFF_RATESEL    8'h10
`define FRFS_OFF_DATA       8'h14
`define FRFS_OFF_SENSE      8'h1C
`define FRFS_OFF_STATUS     8'h20
`define FRFS_OFF_CLEAR      8'h24
`define FRFS_OFF_ENABLE     8'h28
`define FRFS_OFF_SETTINGS   8'h2C
`define FRFS_RATESEL_RESET  8'h02
`define FRFS_RATE_LSB       0
`define FRFS_PRECOMP_LSB    2
`define FRFS_SWRESET_BIT    7
`define FRFS_POWERDOWN_BIT  6
`define FRFS_CHANGE_BIT     7
`define FRFS_PC_000         3'h0
`define FRFS_PC_101         3'h5
`define FRFS_PC_110         3'h6
`define FRFS_PC_111         3'h7
`define FRFS_PS_417         18'd41700
`define FRFS_PS_833         18'd83300
`define FRFS_PS_1250        18'd125000
`define FRFS_PS_1667        18'd166700
`define FRFS_PS_2083        18'd208300
`define FRFS_PS_2500        18'd250000
`define FRFS_CLK_PS         18'd10000
`endif

// ===== core/frfs_pkg.sv
package frfs_pkg;
    typedef enum logic [1:0] {RATE500, RATE300, RATE250, RATE1M} frfs_rate_e;
    typedef logic [7:0] frfs_byte_t;
endpackage

// ===== core/frfs_stack_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frfs_stack_if;
    logic                 push;
    logic                 pop;
    frfs_pkg::frfs_byte_t wrData;
    frfs_pkg::frfs_byte_t rdData;
    logic                 empty;
    logic                 full;
    logic                 flush;
    modport owner (output push, pop, wrData, flush, input rdData, empty, full);
    modport store (input push, pop, wrData, flush, output rdData, empty, full);
endinterface
`default_nettype wire

// ===== core/frfs_byte_stack.sv
`timescale 1ns/1ps
`default_nettype none
module frfs_byte_stack #(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // Stack port
    frfs_stack_if.store   port
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic [7:0]    rd;
    } frfs_stk_s;
    frfs_stk_s   st_reg;
    frfs_stk_s   st_next;
    logic [7:0]  mem [DEPTH];
    logic        doPush;
    logic        doPop;
    assign doPush = port.push && (st_reg.cnt != (AW+1)'(DEPTH));
    assign doPop  = port.pop && (st_reg.cnt != '0);
    assign port.empty  = (st_reg.cnt == '0);
    assign port.full   = (st_reg.cnt == (AW+1)'(DEPTH));
    assign port.rdData = st_reg.rd;
    always_comb
    begin
        st_next = st_reg;
        if (doPush)
            st_next.wp = st_reg.wp + 1'b1;
        if (doPop)
            st_next.rp = st_reg.rp + 1'b1;
        st_next.cnt = st_reg.cnt + (AW+1)'(doPush) - (AW+1)'(doPop);
        if (port.flush)
        begin
            st_next.wp  = '0;
            st_next.rp  = '0;
            st_next.cnt = '0;
        end
        // Single entry onto the read bus, bypassing a write to the head slot
        st_next.rd = mem[st_next.rp];
        if (doPush && (st_reg.wp == st_next.rp))
            st_next.rd = port.wrData;
    end
    always_ff @(posedge clk)
    begin
        if (doPush)
            mem[st_reg.wp] <= port.wrData;
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
endmodule
`default_nettype wire

// ===== core/frfs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "frfs_regs.svh"
module frfs_top #(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AXI4-Lite write address, data and response
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Controller core side
    input  wire logic        ctlResultValid,
    input  wire logic [7:0]  ctlResultByte,
    output logic             ctlCmdValid,
    output logic [7:0]       ctlCmdByte,
    output logic [1:0]       transferRateField,
    output logic [17:0]      precompDelayPs,
    output logic [4:0]       precompDelayCycles,
    output logic             softResetPulse,
    output logic             powerDown,
    // Drive pin
    input  wire logic        media_changed_pin_n,
    // Interrupt
    output logic             irq
);
    typedef struct packed {
        logic        awHeld;
        logic [7:0]  awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        arDone;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic        rdPending;
        logic [7:0]  rdAddr;
        logic [7:0]  rateSel;
        logic [1:0]  rateField;
        logic        cmdValid;
        logic [7:0]  cmdByte;
        logic        swReset;
        logic        pwrDown;
        logic [2:0]  chgSync;
        logic        chgState;
        logic [2:0]  status;
        logic [2:0]  enable;
        logic        irq;
        logic [17:0] pcPs;
        logic [4:0]  pcCyc;
    } frfs_top_s;
    frfs_top_s   st_reg;
    frfs_top_s   st_next;
    frfs_stack_if resIf ();
    frfs_stack_if cmdIf ();
    frfs_byte_stack #(.DEPTH(DEPTH)) u_result (
        .clk  (clk),
        .rst  (rst),
        .port (resIf.store)
    );
    frfs_byte_stack #(.DEPTH(DEPTH)) u_command (
        .clk  (clk),
        .rst  (rst),
        .port (cmdIf.store)
    );
    logic        wrFire;
    logic        rdFire;
    logic [7:0]  sense;
    logic [17:0] pcSel;
    logic [2:0]  pcCode;
    always_comb
    begin
        st_next = st_reg;
        wrFire = 1'b0;
        rdFire = 1'b0;
        sense = 8'h00;
        pcSel = 18'h00000;
        pcCode = st_reg.rateSel[`FRFS_PRECOMP_LSB +: 3];
        resIf.push = ctlResultValid;
        resIf.wrData = ctlResultByte;
        resIf.pop = 1'b0;
        resIf.flush = st_reg.swReset;
        cmdIf.push = 1'b0;
        cmdIf.wrData = st_reg.wData[7:0];
        cmdIf.flush = st_reg.swReset;
        cmdIf.pop = !cmdIf.empty;
        st_next.cmdValid = !cmdIf.empty;
        st_next.cmdByte = cmdIf.rdData;
        st_next.swReset = 1'b0;
        // Pin synchroniser
        st_next.chgSync = {st_reg.chgSync[1:0], media_changed_pin_n};
        if (st_reg.chgSync[2] == st_reg.chgSync[1])
            st_next.chgState = st_reg.chgSync[2];
        sense = {~st_reg.chgState, 7'h00};
        // Write channel
        if (s_axi_awvalid && !st_reg.awHeld && !st_reg.bValid)
        begin
            st_next.awHeld = 1'b1;
            st_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.wHeld && !st_reg.bValid)
        begin
            st_next.wHeld = 1'b1;
            st_next.wData = s_axi_wdata;
            st_next.wStrb = s_axi_wstrb;
        end
        if (st_reg.awHeld && st_reg.wHeld && !st_reg.bValid)
        begin
            wrFire = st_reg.wStrb[0];
            st_next.awHeld = 1'b0;
            st_next.wHeld = 1'b0;
            st_next.bValid = 1'b1;
            st_next.bResp = 2'b00;
            unique case (st_reg.awAddr)
                `FRFS_OFF_RATESEL:
                    if (wrFire)
                    begin
                        st_next.rateSel = st_reg.wData[7:0];
                        st_next.rateField = st_reg.wData[`FRFS_RATE_LSB +: 2];
                        st_next.swReset = st_reg.wData[`FRFS_SWRESET_BIT];
                        st_next.pwrDown = st_reg.wData[`FRFS_POWERDOWN_BIT];
                    end
                `FRFS_OFF_DATA:
                    if (wrFire)
                    begin
                        cmdIf.push = 1'b1;
                        st_next.pwrDown = 1'b0;
                    end
                `FRFS_OFF_SENSE:
                    if (wrFire)
                        st_next.rateField = st_reg.wData[`FRFS_RATE_LSB +: 2];
                `FRFS_OFF_CLEAR:
                    if (wrFire)
                        st_next.status = st_reg.status & ~st_reg.wData[2:0];
                `FRFS_OFF_ENABLE:
                    if (wrFire)
                        st_next.enable = st_reg.wData[2:0];
                default:
                    st_next.bResp = 2'b10;
            endcase
        end
        if (st_reg.bValid && s_axi_bready)
            st_next.bValid = 1'b0;
        // Read channel
        st_next.arDone = 1'b0;
        if (s_axi_arvalid && !st_reg.rdPending && !st_reg.rValid && !st_reg.arDone)
        begin
            st_next.arDone = 1'b1;
            st_next.rdPending = 1'b1;
            st_next.rdAddr = s_axi_araddr;
        end
        if (st_reg.rdPending)
        begin
            rdFire = 1'b1;
            st_next.rdPending = 1'b0;
            st_next.rValid = 1'b1;
            st_next.rResp = 2'b00;
            st_next.rData = 32'h0000_0000;
            unique case (st_reg.rdAddr)
                `FRFS_OFF_DATA:
                begin
                    st_next.rData = {24'h000000, resIf.rdData};
                    resIf.pop = 1'b1;
                    st_next.pwrDown = 1'b0;
                end
                `FRFS_OFF_SENSE:
                    st_next.rData = {24'h000000, sense};
                `FRFS_OFF_STATUS:
                    st_next.rData = {29'h0, st_reg.status};
                `FRFS_OFF_ENABLE:
                    st_next.rData = {29'h0, st_reg.enable};
                `FRFS_OFF_SETTINGS:
                    st_next.rData = {22'h0, st_reg.pwrDown, resIf.empty, cmdIf.full,
                        st_reg.rateSel[4:2], st_reg.rateField, 2'b00};
                `FRFS_OFF_RATESEL, `FRFS_OFF_CLEAR:
                    st_next.rData = 32'h0000_0000;
                default:
                    st_next.rResp = 2'b10;
            endcase
        end
        if (st_reg.rValid && s_axi_rready)
            st_next.rValid = 1'b0;
        // Precompensation delay
        unique case (pcCode)
            `FRFS_PC_000:
                pcSel = (st_reg.rateField == frfs_pkg::RATE1M) ? `FRFS_PS_417
                                                                : `FRFS_PS_1250;
            3'h1:         pcSel = `FRFS_PS_417;
            3'h2:         pcSel = `FRFS_PS_833;
            3'h3:         pcSel = `FRFS_PS_1250;
            3'h4:         pcSel = `FRFS_PS_1667;
            `FRFS_PC_101: pcSel = `FRFS_PS_2083;
            `FRFS_PC_110: pcSel = `FRFS_PS_2500;
            `FRFS_PC_111: pcSel = 18'h00000;
        endcase
        st_next.pcPs = pcSel;
        st_next.pcCyc = 5'((pcSel + `FRFS_CLK_PS / 18'd2) / `FRFS_CLK_PS);
        // Sticky events; set wins over clear
        st_next.status = st_next.status | {resIf.full,
            (st_reg.chgState != st_reg.chgSync[2]) && (st_reg.chgSync[2] == st_reg.chgSync[1]),
            ctlResultValid};
        st_next.irq = |(st_next.status & st_reg.enable);
        if (st_reg.swReset)
            st_next.cmdValid = 1'b0;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
            st_reg.rateSel <= `FRFS_RATESEL_RESET;
            st_reg.rateField <= 2'(frfs_pkg::RATE250);
            st_reg.chgSync <= 3'b111;
            st_reg.chgState <= 1'b1;
            st_reg.pcPs <= `FRFS_PS_1250;
            st_reg.pcCyc <= 5'd13;
        end
        else
            st_reg <= st_next;
    end
    assign s_axi_awready      = st_reg.awHeld;
    assign s_axi_wready       = st_reg.wHeld;
    assign s_axi_bvalid       = st_reg.bValid;
    assign s_axi_bresp        = st_reg.bResp;
    assign s_axi_arready      = st_reg.arDone;
    assign s_axi_rvalid       = st_reg.rValid;
    assign s_axi_rdata        = st_reg.rData;
    assign s_axi_rresp        = st_reg.rResp;
    assign ctlCmdValid        = st_reg.cmdValid;
    assign ctlCmdByte         = st_reg.cmdByte;
    assign transferRateField  = st_reg.rateField;
    assign precompDelayPs     = st_reg.pcPs;
    assign precompDelayCycles = st_reg.pcCyc;
    assign softResetPulse     = st_reg.swReset;
    assign powerDown          = st_reg.pwrDown;
    assign irq                = st_reg.irq;
endmodule
`default_nettype wire

// ===== testbench/frfs_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module frfs_ctl_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Command side
    input  wire logic       ctlCmdValid,
    input  wire logic [7:0] ctlCmdByte,
    output logic [7:0]      lastCmd,
    output logic [7:0]      cmdCount,
    // Result side and pin
    output logic            ctlResultValid,
    output logic [7:0]      ctlResultByte,
    output logic            media_changed_pin_n
);
    initial
    begin
        ctlResultValid = 1'b0;
        ctlResultByte = 8'h00;
        media_changed_pin_n = 1'b1;
    end
    always @(posedge clk)
    begin
        if (rst)
            cmdCount <= 8'h00;
        else if (ctlCmdValid)
        begin
            lastCmd <= ctlCmdByte;
            cmdCount <= cmdCount + 8'h01;
        end
    end
    // One result byte, then the line no longer shows it
    task automatic push_result(input logic [7:0] b);
        ctlResultByte <= b;
        ctlResultValid <= 1'b1;
        @(posedge clk);
        ctlResultValid <= 1'b0;
        ctlResultByte <= ~b;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== testbench/frfs_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "frfs_regs.svh"
module frfs_top_sva (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Bus
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    // Core side
    input  wire logic        ctlCmdValid,
    input  wire logic [1:0]  transferRateField,
    input  wire logic [4:0]  precompDelayCycles,
    input  wire logic        media_changed_pin_n
);
    logic [7:0] wrAddr = 8'h00;
    logic [7:0] wrData = 8'h00;
    logic [7:0] rdAddr = 8'h00;
    logic [3:0] pinAge = 4'h0;
    logic       pinPrev = 1'b1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk)
    begin
        if (s_axi_awvalid && s_axi_awready) wrAddr <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wrData <= s_axi_wdata[7:0];
        if (s_axi_arvalid && s_axi_arready) rdAddr <= s_axi_araddr;
        pinPrev <= media_changed_pin_n;
        if (media_changed_pin_n != pinPrev) pinAge <= 4'h0;
        else if (pinAge != 4'hF) pinAge <= pinAge + 4'h1;
    end
    sequence wr_done_s;
        $fell(s_axi_bvalid);
    endsequence
    sequence sense_rd_s;
        s_axi_rvalid && rdAddr == `FRFS_OFF_SENSE;
    endsequence
    a_rate_reset: assert property ($fell(rst) |-> transferRateField == 2'h2)
        else $error("rate field not at reset value");
    a_cmd_pulse: assert property (ctlCmdValid |=> !ctlCmdValid)
        else $error("command strobe longer than one cycle");
    a_cmd_follows: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_awaddr == `FRFS_OFF_DATA |-> ##[0:6] ctlCmdValid)
        else $error("data port write gave no command byte");
    a_rate_update: assert property (wr_done_s ##0 (wrAddr == `FRFS_OFF_SENSE
        || wrAddr == `FRFS_OFF_RATESEL) |-> transferRateField == wrData[1:0])
        else $error("rate field not taken from write");
    a_precomp_five: assert property (wr_done_s ##0 wrAddr == `FRFS_OFF_RATESEL
        && wrData[4:2] == 3'h5 |-> precompDelayCycles == 5'h15)
        else $error("precomp code five wrong delay");
    a_sense_zero: assert property (sense_rd_s |-> s_axi_rdata[6:0] == 7'h00)
        else $error("sense low bits not zero");
    a_sense_pin: assert property (sense_rd_s ##0 pinAge > 4'hB
        |-> s_axi_rdata[7] == !media_changed_pin_n)
        else $error("sense bit not inverse of pin");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
endmodule
bind frfs_top frfs_top_sva i_frfs_top_sva (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .ctlCmdValid(ctlCmdValid), .transferRateField(transferRateField),
    .precompDelayCycles(precompDelayCycles), .media_changed_pin_n(media_changed_pin_n));
`default_nettype wire

// ===== testbench/test_floppy_rate_fifo_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "frfs_regs.svh"
module test_floppy_rate_fifo_status_regs;
    logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, cmdCount, lastCmd, resByte;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp, rate;
    logic [17:0] ps;
    logic pwrDn;
    logic [4:0] cyc;
    logic resValid, cmdValid, pinN;
    logic [7:0] cmdByte;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    initial forever #5 clk = ~clk;
    frfs_top i_frfs_top (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ctlResultValid(resValid), .ctlResultByte(resByte), .ctlCmdValid(cmdValid),
        .ctlCmdByte(cmdByte), .transferRateField(rate), .precompDelayPs(ps),
        .precompDelayCycles(cyc), .softResetPulse(), .powerDown(pwrDn),
        .media_changed_pin_n(pinN), .irq(irq));
    frfs_ctl_model i_frfs_ctl_model (.clk(clk), .rst(rst), .ctlCmdValid(cmdValid),
        .ctlCmdByte(cmdByte), .lastCmd(lastCmd), .cmdCount(cmdCount),
        .ctlResultValid(resValid), .ctlResultByte(resByte), .media_changed_pin_n(pinN));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp; bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata; r = rresp; rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_rates;
        logic [1:0] r;
        for (int i = 0; i < 4; i++)
        begin
            wr(`FRFS_OFF_RATESEL, i, r);
            check(rate, i);
            check(cyc, (i == 3) ? 5'h04 : 5'h0D);
        end
        check(ps, 16'hA2E4);
        wr(`FRFS_OFF_RATESEL, 32'h95, r);
        check({cyc, rate}, {5'h15, 2'h1});
        wr(`FRFS_OFF_RATESEL, 32'h18, r);
        check(cyc, 5'h19);
        wr(`FRFS_OFF_RATESEL, 32'h4A, r);
        check({pwrDn, cyc, rate}, {1'b1, 5'h08, 2'h2});
        wr(`FRFS_OFF_RATESEL, 32'h00, r);
        wr(`FRFS_OFF_SENSE, 32'h03, r);
        check({cyc, rate}, {5'h04, 2'h3});
    endtask
    task automatic t_data;
        logic [1:0] r;
        logic [31:0] d;
        logic [7:0] n;
        n = cmdCount;
        wr(`FRFS_OFF_DATA, 32'hA5, r);
        for (int i = 0; i < 8 && cmdCount == n; i++) @(posedge clk);
        check({r, lastCmd}, 10'h0A5);
        wr(`FRFS_OFF_ENABLE, 32'h1, r);
        i_frfs_ctl_model.push_result(8'h3C);
        i_frfs_ctl_model.push_result(8'hC3);
        check(irq, 1'b1);
        rd(`FRFS_OFF_DATA, d, r);
        check(d[7:0], 8'h3C);
        rd(`FRFS_OFF_DATA, d, r);
        check(d[7:0], 8'hC3);
        wr(`FRFS_OFF_CLEAR, 32'h1, r);
        check(irq, 1'b0);
    endtask
    task automatic t_sense;
        logic [1:0] r;
        logic [31:0] d;
        for (int p = 0; p < 2; p++)
        begin
            i_frfs_ctl_model.media_changed_pin_n <= p[0];
            repeat (12) @(posedge clk);
            rd(`FRFS_OFF_SENSE, d, r);
            check(d, p ? 32'h0 : 32'h80);
        end
        wr(8'h40, 32'h1, r);
        check(r, 2'h2);
        rd(8'h40, d, r);
        check(r, 2'h2);
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({cyc, rate}, {5'h0D, 2'h2});
        t_rates;
        t_data;
        t_sense;
        tally_and_finish;
    end
endmodule
`default_nettype wire
